// ---- rtl/gpcn_port.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "gpcn_regs.svh"
// Notes on behaviour
// [R1] muxes give peripheral or port output ownership
// [R2] driving peripheral disables port driver, readable
// [R3] idle enabled peripheral lets port drive
// [R4] port output never loops into peripheral
// [R5] direction one is input, zero output
// [R6] reset makes every pin an input
// [R7] latch reads back stored value
// [R8] level reads pins, writes go to latch
// [R9] unimplemented bits disabled, read zero
// [R10] input-only sharing treated as plain port
// [R11] pins frozen through deep sleep until release
// [R12] open-drain bit: drive low or float
// [R13] software sets analog pins as inputs
// [R14] analog pins read zero on level
// [R15] software waits a cycle before reading
// [R16] up to 23 change inputs raise requests
// [R17] change detection works in sleep
// [R18] per-input change enable, two registers
// [R19] per-input pull-up enable, two registers
// [R20] per-input pull-down enable, two registers
// [R21] software never enables both pulls
// [R22] software disables pulls on outputs
// [R23] mismatch sets shared sticky change flag
// [R24] inputs synchronised in two stages
module gpcn_port #(
	parameter int PORT_W = `GPCN_PORT_W,
	parameter int CN_COUNT = `GPCN_CN_COUNT,
	parameter logic [PORT_W-1:0] IMPL_MASK = {PORT_W{1'b1}}
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic sleep_mode,
	input wire logic deep_sleep,
	input wire logic reg_we,
	input wire gpcn_pkg::gpcn_sel_t reg_sel,
	input wire gpcn_pkg::gpcn_data_t reg_wdata,
	input wire logic [PORT_W-1:0] pad_in,
	output logic [PORT_W-1:0] pad_out,
	output logic [PORT_W-1:0] pad_oe,
	input wire logic [PORT_W-1:0] periph_en,
	input wire logic [PORT_W-1:0] periph_oe,
	input wire logic [PORT_W-1:0] periph_out,
	output logic [PORT_W-1:0] periph_in,
	input wire logic [CN_COUNT-1:0] cn_in,
	output logic [CN_COUNT-1:0] pullup_en,
	output logic [CN_COUNT-1:0] pulldown_en,
	output logic [PORT_W-1:0] pin_direction_reg,
	output logic [PORT_W-1:0] output_latch_reg,
	output logic [PORT_W-1:0] pin_level_reg,
	output logic [PORT_W-1:0] open_drain_select_reg,
	output logic [PORT_W-1:0] analog_pin_config_reg,
	output logic [CN_COUNT-1:0] change_irq_enable,
	output logic io_hold_release,
	output logic change_irq
);
	import gpcn_pkg::*;

	localparam int SPLIT = `GPCN_CN_SPLIT;
	localparam int HI_W = CN_COUNT - SPLIT;

	if (PORT_W < 1 || PORT_W > `GPCN_DATA_W) begin : g_bad_port_w
		$error("PORT_W must lie in 1 to data width");
	end
	if (CN_COUNT <= SPLIT || CN_COUNT > 2 * SPLIT) begin : g_bad_cn
		$error("CN_COUNT must lie above split, at most twice it");
	end

	function automatic logic sel_hit(input gpcn_sel_t sel,
			input gpcn_sel_t code);
		sel_hit = reg_we && (sel == code);
	endfunction : sel_hit

	// one low/high register pair folded into one vector
	function automatic logic [CN_COUNT-1:0] cn_merge(
			input logic [CN_COUNT-1:0] old,
			input gpcn_data_t data,
			input logic wr_lo,
			input logic wr_hi);
		logic [CN_COUNT-1:0] res;
		res = old;
		if (wr_lo) begin
			res[SPLIT-1:0] = data[SPLIT-1:0];
		end
		if (wr_hi) begin
			res[CN_COUNT-1:SPLIT] = data[HI_W-1:0];
		end
		cn_merge = res;
	endfunction : cn_merge

	logic core_ce;
	logic [PORT_W-1:0] wdata_port;
	logic [PORT_W-1:0] pad_s1;
	logic [PORT_W-1:0] pad_s2;
	logic [PORT_W-1:0] own;
	logic [PORT_W-1:0] port_drive;
	logic [PORT_W-1:0] next_pad_out;
	logic [PORT_W-1:0] next_pad_oe;
	logic [PORT_W-1:0] next_periph_in;
	logic release_clr;
	gpcn_hold_t hold_state;
	gpcn_hold_t next_hold;

	// sleep stops the core clock; change detection and the hold state keep running
	assign core_ce = clk_en & ~sleep_mode;
	assign wdata_port = reg_wdata[PORT_W-1:0];

	// [R5] direction writes; [R9] absent bits forced to zero
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			// [R6] all implemented pins inputs
			pin_direction_reg <= IMPL_MASK;
		end else if (core_ce && sel_hit(reg_sel, `GPCN_SEL_DIR)) begin
			pin_direction_reg <= wdata_port & IMPL_MASK;
		end
	end

	// [R7] latch holds last written value
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			output_latch_reg <= '0;
		end else if (core_ce && (sel_hit(reg_sel, `GPCN_SEL_LATCH)
				|| sel_hit(reg_sel, `GPCN_SEL_LEVEL))) begin
			// [R8] level writes land in the latch
			output_latch_reg <= wdata_port & IMPL_MASK;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			open_drain_select_reg <= '0;
			analog_pin_config_reg <= '0;
		end else if (core_ce) begin
			// [R12] per-pin open-drain select
			if (sel_hit(reg_sel, `GPCN_SEL_ODC)) begin
				open_drain_select_reg <= wdata_port & IMPL_MASK;
			end
			if (sel_hit(reg_sel, `GPCN_SEL_ANALOG)) begin
				analog_pin_config_reg <= wdata_port & IMPL_MASK;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			change_irq_enable <= '0;
			pullup_en <= '0;
			pulldown_en <= '0;
		end else if (core_ce) begin
			// [R18] enables span two registers
			change_irq_enable <= cn_merge(change_irq_enable, reg_wdata,
				sel_hit(reg_sel, `GPCN_SEL_CNEN_LO),
				sel_hit(reg_sel, `GPCN_SEL_CNEN_HI));
			// [R19] pull-ups span two registers
			pullup_en <= cn_merge(pullup_en, reg_wdata,
				sel_hit(reg_sel, `GPCN_SEL_PU_LO),
				sel_hit(reg_sel, `GPCN_SEL_PU_HI));
			// [R20] pull-downs span two registers
			pulldown_en <= cn_merge(pulldown_en, reg_wdata,
				sel_hit(reg_sel, `GPCN_SEL_PD_LO),
				sel_hit(reg_sel, `GPCN_SEL_PD_HI));
		end
	end

	// [R24] two-stage pin synchroniser
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pad_s1 <= '0;
			pad_s2 <= '0;
		end else if (core_ce) begin
			pad_s1 <= pad_in;
			pad_s2 <= pad_s1;
		end
	end

	// level readback trails the pin by three edges, hence the wait
	// [R14] analog pins masked; [R15] latency covered by the gap
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pin_level_reg <= '0;
		end else if (core_ce) begin
			pin_level_reg <= pad_s2 & ~analog_pin_config_reg & IMPL_MASK;
		end
	end

	// [R11] hold engages on deep sleep, leaves only on release clear
	assign release_clr = sel_hit(reg_sel, `GPCN_SEL_HOLD)
		&& !reg_wdata[`GPCN_HOLD_RELEASE_BIT];

	always_comb begin
		next_hold = hold_state;
		case (hold_state)
			GPCN_RUN: begin
				if (deep_sleep) begin
					next_hold = GPCN_HOLD;
				end
			end
			GPCN_HOLD: begin
				if (release_clr && !deep_sleep) begin
					next_hold = GPCN_RUN;
				end
			end
			default: begin
				next_hold = GPCN_RUN;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			hold_state <= GPCN_RUN;
			io_hold_release <= 1'b0;
		end else if (clk_en) begin
			hold_state <= next_hold;
			io_hold_release <= (next_hold == GPCN_HOLD);
		end
	end

	// [R1] ownership: a driving peripheral takes the pin
	// [R10] input-only sharers never set periph_oe, so the port keeps it
	assign own = periph_en & periph_oe & IMPL_MASK;
	// [R3] an idle peripheral leaves the port in charge
	assign port_drive = ~pin_direction_reg & IMPL_MASK & ~own;

	for (genvar gi = 0; gi < PORT_W; gi++) begin : g_pin
		always_comb begin
			if (own[gi]) begin
				// [R2] port driver off, peripheral drives
				next_pad_out[gi] = periph_out[gi];
				next_pad_oe[gi] = 1'b1;
			end else if (open_drain_select_reg[gi]) begin
				// [R12] only low is driven, high floats
				next_pad_out[gi] = 1'b0;
				next_pad_oe[gi] = port_drive[gi]
					& ~output_latch_reg[gi];
			end else begin
				next_pad_out[gi] = output_latch_reg[gi];
				next_pad_oe[gi] = port_drive[gi];
			end
		end
		// [R4] a port-driven pin shows the peripheral a quiet low
		assign next_periph_in[gi] = port_drive[gi] ? 1'b0 : pad_s2[gi];
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pad_out <= '0;
			pad_oe <= '0;
		end else if (core_ce && hold_state == GPCN_RUN) begin
			pad_out <= next_pad_out;
			pad_oe <= next_pad_oe;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			periph_in <= '0;
		end else if (core_ce) begin
			periph_in <= next_periph_in;
		end
	end

	// [R17] detector sees clk_en, not the sleeping core enable
	gpcn_cn_if #(.CN_COUNT(CN_COUNT)) cn ();

	assign cn.raw = cn_in;
	assign cn.en = change_irq_enable;
	// [R23] a write to the flag selector clears it unless a change sets it in the same cycle
	assign cn.clr = sel_hit(reg_sel, `GPCN_SEL_CNFLAG);

	gpcn_change #(.CN_COUNT(CN_COUNT)) u_change (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.cn(cn.det)
	);

	assign change_irq = cn.flag;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	a_dir_reset: assert property ( // [R6]
		$rose(resetn) |-> pin_direction_reg == IMPL_MASK
	) else $error("direction not input after reset");

	a_dir_write: assert property ( // [R5]
		core_ce && sel_hit(reg_sel, `GPCN_SEL_DIR)
			|=> pin_direction_reg == ($past(wdata_port) & IMPL_MASK)
	) else $error("direction write lost");

	a_level_to_latch: assert property ( // [R8]
		core_ce && sel_hit(reg_sel, `GPCN_SEL_LEVEL)
			|=> output_latch_reg == ($past(wdata_port) & IMPL_MASK)
	) else $error("level write missed latch");

	a_unimpl_zero: assert property ( // [R9]
		((pin_direction_reg | output_latch_reg | pin_level_reg
			| pad_oe) & ~IMPL_MASK) == '0
	) else $error("unimplemented bit nonzero");

	a_analog_zero: assert property ( // [R14]
		core_ce |=> (pin_level_reg & $past(analog_pin_config_reg)) == '0
	) else $error("analog pin read nonzero");

	a_periph_owns: assert property ( // [R2]
		core_ce && hold_state == GPCN_RUN
			|=> ((pad_out ^ $past(periph_out)) & $past(own)) == '0
			&& (pad_oe & $past(own)) == $past(own)
	) else $error("peripheral lost its pin");

	a_port_fallback: assert property ( // [R3]
		core_ce && hold_state == GPCN_RUN
			|=> (pad_oe & $past(port_drive & ~open_drain_select_reg))
			== $past(port_drive & ~open_drain_select_reg)
	) else $error("port not driving free pin");

	a_od_no_high: assert property ( // [R12]
		core_ce && hold_state == GPCN_RUN
			|=> (pad_oe & pad_out
			& $past(open_drain_select_reg & ~own)) == '0
	) else $error("open-drain pin driven high");

	a_no_loop: assert property ( // [R4]
		core_ce |=> (periph_in & $past(port_drive)) == '0
	) else $error("port output looped to peripheral");

	a_hold_entry: assert property ( // [R11]
		clk_en && deep_sleep |=> hold_state == GPCN_HOLD
			&& io_hold_release
	) else $error("hold not taken");

	a_hold_freeze: assert property ( // [R11]
		hold_state == GPCN_HOLD |=> $stable(pad_out) && $stable(pad_oe)
	) else $error("pins moved while held");

	a_sleep_detect: assert property ( // [R17]
		clk_en && sleep_mode && (|u_change.change) |=> change_irq
	) else $error("change missed in sleep");
endmodule : gpcn_port
`default_nettype wire

// ---- pkg/gpcn_regs.svh ----
`ifndef GPCN_REGS_SVH
`define GPCN_REGS_SVH

`define GPCN_DATA_W 16
`define GPCN_SEL_W 4
`define GPCN_PORT_W 16
`define GPCN_CN_COUNT 23
`define GPCN_CN_SPLIT 16

`define GPCN_SEL_DIR 4'h0
`define GPCN_SEL_LATCH 4'h1
`define GPCN_SEL_LEVEL 4'h2
`define GPCN_SEL_ODC 4'h3
`define GPCN_SEL_ANALOG 4'h4
`define GPCN_SEL_CNEN_LO 4'h5
`define GPCN_SEL_CNEN_HI 4'h6
`define GPCN_SEL_PU_LO 4'h7
`define GPCN_SEL_PU_HI 4'h8
`define GPCN_SEL_PD_LO 4'h9
`define GPCN_SEL_PD_HI 4'ha
`define GPCN_SEL_HOLD 4'hb
`define GPCN_SEL_CNFLAG 4'hc

`define GPCN_HOLD_RELEASE_BIT 0
`define GPCN_RST_ZERO 16'h0000

`endif

// ---- pkg/gpcn_pkg.sv ----
`default_nettype none
package gpcn_pkg;
`include "gpcn_regs.svh"

	typedef logic [`GPCN_SEL_W-1:0] gpcn_sel_t;
	typedef logic [`GPCN_DATA_W-1:0] gpcn_data_t;
	typedef enum logic [1:0] {
		GPCN_RUN = 2'b01,
		GPCN_HOLD = 2'b10
	} gpcn_hold_t;
endpackage : gpcn_pkg
`default_nettype wire

// ---- pkg/gpcn_cn_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface gpcn_cn_if #(
	parameter int CN_COUNT = 23
);
	logic [CN_COUNT-1:0] raw;
	logic [CN_COUNT-1:0] en;
	logic clr;
	logic flag;

	modport ctl (
		output raw,
		output en,
		output clr,
		input flag
	);
	modport det (
		input raw,
		input en,
		input clr,
		output flag
	);
endinterface : gpcn_cn_if
`default_nettype wire

// ---- rtl/gpcn_change.sv ----
`timescale 1ns/1ns
`default_nettype none
module gpcn_change #(
	parameter int CN_COUNT = 23
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clk_en,
	gpcn_cn_if.det cn
);
	import gpcn_pkg::*;

	logic [CN_COUNT-1:0] cn_s1;
	logic [CN_COUNT-1:0] cn_s2;
	logic [CN_COUNT-1:0] cn_prev;
	logic [CN_COUNT-1:0] change;
	logic flag;

	// stays on the free clock so sleep does not blind it
	// [R24] two-stage capture
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cn_s1 <= '0;
			cn_s2 <= '0;
			cn_prev <= '0;
		end else if (clk_en) begin
			cn_s1 <= cn.raw;
			cn_s2 <= cn_s1;
			cn_prev <= cn_s2;
		end
	end

	// [R16] per-input mismatch
	assign change = (cn_s2 ^ cn_prev) & cn.en;

	// [R23] sticky flag, set beats clear
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			flag <= 1'b0;
		end else if (clk_en) begin
			flag <= (flag & ~cn.clr) | (|change);
		end
	end

	assign cn.flag = flag;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	a_flag_sets: assert property ( // [R23]
		clk_en && (|change) |=> flag
	) else $error("change not flagged");

	a_flag_sticks: assert property ( // [R23]
		clk_en && flag && !cn.clr |=> flag
	) else $error("flag dropped without clear");

	a_masked_quiet: assert property ( // [R18]
		clk_en && !flag && ((cn_s2 ^ cn_prev) & ~cn.en) != '0
			&& change == '0 |=> !flag
	) else $error("disabled input raised flag");
endmodule : gpcn_change
`default_nettype wire

// ---- testbench/gpcn_pin_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module gpcn_pin_model (
	input wire logic ref_clk,
	input wire logic [15:0] pad_out,
	input wire logic [15:0] pad_oe,
	input wire logic [15:0] ext_oe,
	input wire logic [15:0] ext_val,
	output logic [15:0] pad_in
);
	logic [15:0] float_pat = 16'h5555;
	// floating pins wander so a stale level never passes
	always @(posedge ref_clk) begin
		float_pat <= ~float_pat;
	end
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_oe & ext_val) |
		(~pad_oe & ~ext_oe & float_pat);
endmodule : gpcn_pin_model
`default_nettype wire

// ---- testbench/gpcn_port_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module gpcn_port_tb;
	import gpcn_pkg::*;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic sleep_mode = 1'b0;
	logic deep_sleep = 1'b0;
	logic reg_we = 1'b0;
	gpcn_sel_t reg_sel = 4'h0;
	gpcn_data_t reg_wdata = 16'h0000;
	logic [15:0] periph_en = 16'h0000;
	logic [15:0] periph_oe = 16'h0000;
	logic [15:0] periph_out = 16'h0000;
	logic [15:0] ext_oe = 16'h0000;
	logic [15:0] ext_val = 16'h0000;
	logic [22:0] cn_in = 23'h00_0000;
	logic [15:0] pad_in, pad_out, pad_oe, periph_in, frozen;
	logic [15:0] dir_q, lat_q, lvl_q, odc_q, ana_q;
	logic [22:0] pu_q, pd_q, cnen_q;
	logic hold_q, irq_q;
	int n_mismatch = 0;
	int total_checks = 0;

	always #5 ref_clk = ~ref_clk;

	// bit 15 left unimplemented to exercise masking
	gpcn_port #(.IMPL_MASK(16'h7fff)) gpcn_port_inst (
		.ref_clk(ref_clk), .resetn(resetn), .clk_en(1'b1),
		.sleep_mode(sleep_mode), .deep_sleep(deep_sleep),
		.reg_we(reg_we), .reg_sel(reg_sel), .reg_wdata(reg_wdata),
		.pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
		.periph_en(periph_en), .periph_oe(periph_oe),
		.periph_out(periph_out), .periph_in(periph_in),
		.cn_in(cn_in), .pullup_en(pu_q), .pulldown_en(pd_q),
		.pin_direction_reg(dir_q), .output_latch_reg(lat_q),
		.pin_level_reg(lvl_q), .open_drain_select_reg(odc_q),
		.analog_pin_config_reg(ana_q), .change_irq_enable(cnen_q),
		.io_hold_release(hold_q), .change_irq(irq_q)
	);

	gpcn_pin_model gpcn_pin_model_inst (
		.ref_clk(ref_clk), .pad_out(pad_out), .pad_oe(pad_oe),
		.ext_oe(ext_oe), .ext_val(ext_val), .pad_in(pad_in)
	);

	task automatic chk(input logic [22:0] got, input logic [22:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : cyc

	task automatic wr(input gpcn_sel_t s, input gpcn_data_t d);
		@(negedge ref_clk);
		reg_we = 1'b1;
		reg_sel = s;
		reg_wdata = d;
		@(negedge ref_clk);
		reg_we = 1'b0;
		@(negedge ref_clk);
	endtask : wr

	task automatic fin(input string name);
		$display("test %s finished", name);
	endtask : fin

	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : summarize

	initial begin
		cyc(5000);
		n_mismatch++;
		$display("BAD t=%0t watchdog expired", $time);
		summarize();
	end

	initial begin
		cyc(12);
		resetn = 1'b1;
		chk(dir_q, 16'h7fff);
		chk(lat_q, 16'h0000);
		chk(pad_oe, 16'h0000);
		fin("reset");
		wr(4'h1, 16'hffff);
		chk(lat_q, 16'h7fff);
		wr(4'h1, 16'h005a);
		chk(lat_q, 16'h005a);
		wr(4'h0, 16'hff00);
		chk(dir_q, 16'h7f00);
		chk(pad_oe, 16'h00ff);
		chk(pad_out & 16'h00ff, 16'h005a);
		fin("direction");
		wr(4'h2, 16'h00a5);
		chk(lat_q, 16'h00a5);
		ext_oe = 16'hff00;
		ext_val = 16'hc300;
		// analog pin 14 stays an input
		wr(4'h4, 16'h4000);
		chk(ana_q, 16'h4000);
		cyc(3);
		chk(lvl_q, 16'h03a5);
		ext_val = 16'h0000;
		cyc(2);
		chk(lvl_q, 16'h03a5);
		cyc(1);
		chk(lvl_q, 16'h00a5);
		fin("readback");
		wr(4'h3, 16'h8001);
		chk(odc_q, 16'h0001);
		chk(pad_oe[0], 1'b0);
		wr(4'h1, 16'h00a4);
		chk(pad_oe[0], 1'b1);
		chk(pad_out[0], 1'b0);
		wr(4'h3, 16'h0000);
		fin("open drain");
		periph_en = 16'h0002;
		periph_oe = 16'h0002;
		periph_out = 16'h0002;
		cyc(2);
		chk(pad_oe[1], 1'b1);
		chk(pad_out[1], 1'b1);
		cyc(3);
		chk(lvl_q[1], 1'b1);
		chk(periph_in[1], 1'b1);
		periph_oe = 16'h0000;
		cyc(2);
		chk(pad_out[1], 1'b0);
		wr(4'h1, 16'h00a6);
		cyc(3);
		chk(pad_out[1], 1'b1);
		chk(periph_in[1], 1'b0);
		fin("sharing");
		// each pull on its own input pin
		wr(4'h7, 16'h0001);
		wr(4'h8, 16'h0002);
		wr(4'h9, 16'h0004);
		wr(4'ha, 16'h0040);
		chk(pu_q, 23'h02_0001);
		chk(pd_q, 23'h40_0004);
		fin("pulls");
		wr(4'h5, 16'h0001);
		wr(4'h6, 16'h0010);
		chk(cnen_q, 23'h10_0001);
		cn_in[3] = 1'b1;
		cyc(5);
		chk(irq_q, 1'b0);
		cn_in[20] = 1'b1;
		cyc(2);
		chk(irq_q, 1'b0);
		cyc(1);
		chk(irq_q, 1'b1);
		cyc(3);
		chk(irq_q, 1'b1);
		wr(4'hc, 16'h0000);
		chk(irq_q, 1'b0);
		sleep_mode = 1'b1;
		cn_in[20] = 1'b0;
		wr(4'h1, 16'h0000);
		cyc(1);
		chk(irq_q, 1'b1);
		chk(lat_q, 16'h00a6);
		sleep_mode = 1'b0;
		wr(4'hc, 16'h0000);
		chk(irq_q, 1'b0);
		fin("change notify");
		deep_sleep = 1'b1;
		cyc(2);
		chk(hold_q, 1'b1);
		frozen = pad_out;
		deep_sleep = 1'b0;
		wr(4'h1, 16'h00ff);
		cyc(2);
		chk(pad_out, frozen);
		wr(4'hb, 16'h0000);
		cyc(1);
		chk(hold_q, 1'b0);
		chk(pad_out & 16'h00ff, 16'h00ff);
		fin("hold");
		resetn = 1'b0;
		cyc(2);
		resetn = 1'b1;
		chk(dir_q, 16'h7fff);
		chk(pad_oe, 16'h0000);
		fin("second reset");
		summarize();
	end
endmodule : gpcn_port_tb
`default_nettype wire
